// ---- cglc_pkg.sv ----
// Constants and carrier types for the counter gate, latch and compare block
// Assumes a 125 MHz system clock
package cglc_pkg;

  // ==========================================
  // Timing
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned PULSE_STEP_MS = 2;
  localparam int unsigned PULSE_MAX_MS = 510;
  localparam int unsigned PULSE_STEP_CYC = PULSE_STEP_MS * CLK_KHZ;
  localparam int unsigned PULSE_MAX_UNITS = PULSE_MAX_MS / PULSE_STEP_MS;

  // ==========================================
  // Pin vector layout, reset values and hysteresis threshold
  localparam int PIN_CNT = 0;
  localparam int PIN_DIR = 1;
  localparam int PIN_HWG = 2;
  localparam int PIN_LAT = 3;
  localparam int PIN_W = 4;
  localparam logic [31:0] CNT_RST = 32'h00000000;
  localparam logic [7:0] HYST_OFF_MAX = 8'h01;

  // ==========================================
  // Modes
  typedef enum logic [1:0] {
    CGLC_CMP_NONE = 2'b00,
    CGLC_CMP_GE = 2'b01,
    CGLC_CMP_LE = 2'b10,
    CGLC_CMP_PULSE = 2'b11
  } cglc_cmp_mode_t;

  typedef enum logic [1:0] {
    CGLC_DIR_NONE = 2'b00,
    CGLC_DIR_UP = 2'b01,
    CGLC_DIR_DOWN = 2'b10,
    CGLC_DIR_RSVD = 2'b11
  } cglc_dir_mode_t;

  // Software configuration of one channel
  typedef struct packed {
    logic gate_stop;
    logic hardware_gate_input_en;
    logic count_once;
    cglc_cmp_mode_t cmp_mode;
    cglc_dir_mode_t dir_mode;
    logic ctrl_do;
    logic plain_do;
    logic [7:0] pulse_units;
    logic [7:0] hysteresis;
    logic [31:0] end_value;
    logic [31:0] cmp_value;
    logic [31:0] load_value;
  } cglc_cfg_t;

endpackage : cglc_pkg

// ---- cglc_top.sv ----
// Gate control, latch, comparator and pulse output for one 32-bit counter channel
// Pins arrive asynchronously; software gate and configuration are on clk
`timescale 1ns/10ps
// How it works
// - Config selects cancel or stop reaction and enables hardware gate use.
// - No hardware gate, cancel: software gate rise reloads the load value.
// - No hardware gate, stop: software gate rise continues from held count.
// - Hardware gate, cancel: software rise continues, hardware rise reloads.
// - Hardware gate, stop: either gate rise continues counting.
// - Count once: after auto close, reopen by hardware rise with software high, or by software rise without hardware gate.
// - Latch pin rise while counting copies the count to the latch register.
// - Latched value is kept until the next capture; only reset clears it.
// - A writable comparison value drives output, status bit and interrupt.
// - No comparison: output is plain, control bit ignored, status bits cleared.
// - Greater/less-or-equal: output follows result while control bit set.
// - Comparator status clears only when the condition is no longer met.
// - Pulse mode: reaching the comparison value fires a timed output pulse.
// - Pulse fires only when reached in the configured main direction.
// - In pulse mode comparator status mirrors the output until pulse ends.
// - Pulse duration 0 to 510 ms in 2 ms steps.
// - Pulse timing starts with output assertion, error under 1 ms.
// - A running pulse is never retriggered or extended.
// - A new duration applies only from the next pulse.
// - Internal gate combines software and hardware gates, hardware optional.
// - Hysteresis 0 to 255; 0 and 1 disable it.
// - With hysteresis the result freezes until the count leaves the range.
module cglc_top import cglc_pkg::*; #(
  parameter int unsigned STEP_CYCLES = PULSE_STEP_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire cglc_cfg_t cfg,
  input wire logic software_gate,
  input wire logic count_pulse_pin,
  input wire logic count_dir_pin,
  input wire logic hardware_gate_input,
  input wire logic latch_pin,
  output logic [31:0] counter_value,
  output logic [31:0] latched_count_value,
  output logic internal_gate,
  output logic digital_out,
  output logic comparator_status_bit,
  output logic output_status_bit,
  output logic hw_irq
);

  // ==========================================
  // Pin synchronisers and edge detection
  logic [PIN_W-1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
  logic [PIN_W-1:0] pin_raw, pin_rise;
  logic sw_q_reg;

  assign pin_raw = {latch_pin, hardware_gate_input, count_dir_pin, count_pulse_pin};

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
      sw_q_reg <= 1'b0;
    end else if (ce) begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      sw_q_reg <= software_gate;
    end
  end

  assign pin_rise = pin_s2_reg & ~pin_s3_reg;

  // ==========================================
  // Gate, counter and latch
  logic [31:0] cnt_reg, cnt_next, lat_reg, lat_next;
  logic igate_reg, igate_next, closed_reg, closed_next;
  logic sw_rise, hw_lvl, hw_rise, up, step, gate_cond, reopen, load_ev, auto_close;
  logic signed [33:0] cnt_w, end_w;

  assign sw_rise = software_gate & ~sw_q_reg;
  assign hw_lvl = pin_s2_reg[PIN_HWG];
  assign hw_rise = pin_rise[PIN_HWG];
  assign up = pin_s2_reg[PIN_DIR];
  assign step = igate_reg & pin_rise[PIN_CNT];
  assign cnt_w = 34'($signed(cnt_reg));
  assign end_w = 34'($signed(cfg.end_value));

  always_comb begin
    gate_cond = cfg.hardware_gate_input_en ? (software_gate & hw_lvl) : software_gate;
    reopen = cfg.hardware_gate_input_en ? (hw_rise & software_gate) : sw_rise;
    auto_close = cfg.count_once & step &
      (up ? (cnt_w + 34'sd1 == end_w) : (cnt_w - 34'sd1 == end_w));
    if (closed_reg) begin
      load_ev = reopen;
    end else if (cfg.hardware_gate_input_en) begin
      load_ev = hw_rise & software_gate & ~cfg.gate_stop;
    end else begin
      load_ev = sw_rise & ~cfg.gate_stop;
    end
    closed_next = (closed_reg & ~reopen) | auto_close;
    igate_next = gate_cond & ~closed_next;
    cnt_next = cnt_reg;
    if (load_ev || auto_close) begin
      cnt_next = cfg.load_value;
    end else if (step) begin
      cnt_next = up ? cnt_reg + 32'h00000001 : cnt_reg - 32'h00000001;
    end
    // Capture on latch rise while counting only
    lat_next = (igate_reg & pin_rise[PIN_LAT]) ? cnt_reg : lat_reg;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg <= CNT_RST;
      lat_reg <= CNT_RST;
      igate_reg <= 1'b0;
      closed_reg <= 1'b0;
    end else if (ce) begin
      cnt_reg <= cnt_next;
      lat_reg <= lat_next;
      igate_reg <= igate_next;
      closed_reg <= closed_next;
    end
  end

  // ==========================================
  // Comparator, hysteresis and pulse timer
  logic res_reg, res_next, hyst_reg, hyst_next, busy_reg, busy_next;
  logic do_reg, do_next, cmps_reg, cmps_next, outs_reg, outs_next, irq_reg, irq_next;
  logic [31:0] presc_reg, presc_next;
  logic [7:0] units_reg, units_next;
  logic signed [33:0] cmp_w, hys_w;
  logic cmp_raw, in_range, hyst_on, reach, dir_ok, pulse_start, step_end;

  assign cmp_w = 34'($signed(cfg.cmp_value));
  assign hys_w = 34'(cfg.hysteresis);
  assign in_range = (cnt_w >= cmp_w - hys_w) && (cnt_w <= cmp_w + hys_w);
  // Settings 0 and 1 disable hysteresis
  assign hyst_on = cfg.hysteresis > HYST_OFF_MAX;
  assign step_end = presc_reg == 32'(STEP_CYCLES - 1);

  always_comb begin
    // Raw comparison against the comparison value
    cmp_raw = (cfg.cmp_mode == CGLC_CMP_GE) ? ($signed(cnt_reg) >= $signed(cfg.cmp_value)) :
      ($signed(cnt_reg) <= $signed(cfg.cmp_value));
    reach = (cnt_next == cfg.cmp_value) && (cnt_reg != cfg.cmp_value) && step;
    dir_ok = (cfg.dir_mode == CGLC_DIR_NONE) || ((cfg.dir_mode == CGLC_DIR_UP) && up) ||
      ((cfg.dir_mode == CGLC_DIR_DOWN) && !up);
    // Start only when idle and not inside a hysteresis band
    pulse_start = (cfg.cmp_mode == CGLC_CMP_PULSE) && cfg.ctrl_do && reach && dir_ok &&
      !busy_reg && !hyst_reg && (cfg.pulse_units != 8'h00);
    // Freeze result while hysteresis is active
    res_next = res_reg;
    hyst_next = hyst_reg;
    if (hyst_reg) begin
      if (!in_range) begin
        hyst_next = 1'b0;
        res_next = cmp_raw;
      end
    end else begin
      res_next = cmp_raw;
      if (hyst_on && ((cmp_raw && !res_reg) || reach)) begin
        hyst_next = 1'b1;
      end
    end
    // Duration latched at start, counted in 2 ms units
    busy_next = busy_reg;
    presc_next = presc_reg;
    units_next = units_reg;
    if (pulse_start) begin
      busy_next = 1'b1;
      presc_next = 32'h00000000;
      units_next = cfg.pulse_units;
    end else if (busy_reg) begin
      if (step_end) begin
        presc_next = 32'h00000000;
        units_next = units_reg - 8'h01;
        busy_next = units_reg != 8'h01;
      end else begin
        presc_next = presc_reg + 32'h00000001;
      end
    end
    irq_next = pulse_start;
    unique case (cfg.cmp_mode)
      // Plain output, status bits held cleared
      CGLC_CMP_NONE: begin
        do_next = cfg.plain_do;
        cmps_next = 1'b0;
        outs_next = 1'b0;
      end
      // Output gated by control bit, status follows result
      CGLC_CMP_GE, CGLC_CMP_LE: begin
        do_next = cfg.ctrl_do & res_next;
        cmps_next = res_next;
        outs_next = cfg.ctrl_do & res_next;
        irq_next = res_next & ~res_reg;
      end
      CGLC_CMP_PULSE: begin
        do_next = busy_next;
        cmps_next = busy_next;
        outs_next = busy_next;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      res_reg <= 1'b0;
      hyst_reg <= 1'b0;
      busy_reg <= 1'b0;
      presc_reg <= 32'h00000000;
      units_reg <= 8'h00;
      do_reg <= 1'b0;
      cmps_reg <= 1'b0;
      outs_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else if (ce) begin
      res_reg <= res_next;
      hyst_reg <= hyst_next;
      busy_reg <= busy_next;
      presc_reg <= presc_next;
      units_reg <= units_next;
      do_reg <= do_next;
      cmps_reg <= cmps_next;
      outs_reg <= outs_next;
      irq_reg <= irq_next;
    end
  end

  assign counter_value = cnt_reg;
  assign latched_count_value = lat_reg;
  assign internal_gate = igate_reg;
  assign digital_out = do_reg;
  assign comparator_status_bit = cmps_reg;
  assign output_status_bit = outs_reg;
  assign hw_irq = irq_reg;

  // ==========================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_sw_cancel_load: assert property (ce && !cfg.hardware_gate_input_en && !cfg.gate_stop && sw_rise && !closed_reg
    |=> cnt_reg == $past(cfg.load_value)) else $error("cancel did not reload");
  a_sw_stop_keep: assert property (ce && !cfg.hardware_gate_input_en && cfg.gate_stop && sw_rise && !igate_reg
    && !closed_reg |=> cnt_reg == $past(cnt_reg)) else $error("stop changed count");
  a_hw_cancel_load: assert property (ce && cfg.hardware_gate_input_en && !cfg.gate_stop && hw_rise && software_gate
    |=> cnt_reg == $past(cfg.load_value)) else $error("hw cancel did not reload");
  a_hardware_gate_input_and: assert property (ce && cfg.hardware_gate_input_en && !(software_gate && hw_lvl)
    |=> !igate_reg) else $error("gate open without both gates");
  a_once_stays_closed: assert property (ce && closed_reg && !reopen |=> !igate_reg)
    else $error("count once reopened wrongly");
  a_latch_copy: assert property (ce && igate_reg && pin_rise[PIN_LAT]
    |=> latched_count_value == $past(cnt_reg)) else $error("latch missed");
  a_none_status: assert property (ce && cfg.cmp_mode == CGLC_CMP_NONE
    |=> !comparator_status_bit && !output_status_bit && digital_out == $past(cfg.plain_do))
    else $error("no-compare mode status set");
  a_status_fall: assert property (ce && cmps_reg && !cmp_raw && !hyst_reg
    && cfg.cmp_mode == CGLC_CMP_GE |=> !cmps_reg) else $error("status not cleared");
  a_pulse_no_retrig: assert property (ce && busy_reg && !step_end |=> busy_reg &&
    units_reg == $past(units_reg)) else $error("pulse retriggered or cut");
  a_pulse_start_out: assert property (ce && pulse_start |=> digital_out && comparator_status_bit
    && units_reg == $past(cfg.pulse_units) && presc_reg == 32'h00000000) else $error("pulse start wrong");

  c_pulse_run: cover property (ce && pulse_start ##1 busy_reg [*3]);
  c_latch_hit: cover property (ce && igate_reg && pin_rise[PIN_LAT]);
  c_once_reopen: cover property (closed_reg && reopen && ce);
  c_hyst_freeze: cover property (hyst_reg && cmp_raw != res_reg);

endmodule : cglc_top

// ---- cglc_pins_model.sv ----
// Far-side pin model: count pulses, direction, hardware gate and latch
// Driven from the bench clock; pin levels are held three clock cycles, the hardware gate six
`timescale 1ns/10ps
module cglc_pins_model (
  input wire logic clk,
  output logic count_pulse_pin,
  output logic count_dir_pin,
  output logic hardware_gate_input,
  output logic latch_pin
);
  initial begin
    count_pulse_pin = 1'b0;
    count_dir_pin = 1'b1;
    hardware_gate_input = 1'b0;
    latch_pin = 1'b0;
  end
  // Holds long enough for the two-stage synchroniser
  task automatic hold3;
    repeat (3) @(posedge clk);
  endtask : hold3
  // Burst of count pulses in one direction
  task automatic pulses(input int n, input logic up);
    count_dir_pin <= up;
    hold3();
    repeat (n) begin
      count_pulse_pin <= 1'b1;
      hold3();
      count_pulse_pin <= 1'b0;
      hold3();
    end
  endtask : pulses
  task automatic hwg(input logic v);
    hardware_gate_input <= v;
    hold3();
    hold3();
  endtask : hwg
  task automatic latch;
    latch_pin <= 1'b1;
    hold3();
    latch_pin <= 1'b0;
    hold3();
  endtask : latch
endmodule : cglc_pins_model

// ---- cglc_top_tb.sv ----
// Self-checking bench for the counter gate, latch and compare block
// Uses the pin model for the far side; pulse unit shortened to 4 cycles
`timescale 1ns/10ps
module cglc_top_tb import cglc_pkg::*;;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic sw = 1'b0;
  cglc_cfg_t cfg = '0;
  logic [31:0] cnt, lat;
  logic ig, dout, cst, ost, irq, cp, cd, hg, lp;
  int bad_count = 0;
  int compares = 0;
  int n;
  int irq_cnt = 0;
  logic seen;
  always #4 clk = ~clk;
  cglc_pins_model i_cglc_pins_model (.clk(clk), .count_pulse_pin(cp), .count_dir_pin(cd),
    .hardware_gate_input(hg), .latch_pin(lp));
  cglc_top #(.STEP_CYCLES(4)) i_cglc_top (.clk(clk), .srst(srst), .ce(ce), .cfg(cfg),
    .software_gate(sw), .count_pulse_pin(cp), .count_dir_pin(cd), .hardware_gate_input(hg),
    .latch_pin(lp), .counter_value(cnt), .latched_count_value(lat), .internal_gate(ig),
    .digital_out(dout), .comparator_status_bit(cst), .output_status_bit(ost), .hw_irq(irq));
  // ==========================================
  // Helpers
  task automatic step(input int k);
    repeat (k) @(posedge clk);
  endtask : step
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk32
  task automatic chk1(input logic got, input logic exp, input string what);
    chk32({31'h0, got}, {31'h0, exp}, what);
  endtask : chk1
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic sw_set(input logic v);
    sw <= v;
    step(2);
  endtask : sw_set
  // ==========================================
  // Scenarios
  task automatic t_soft_gate;
    cfg.load_value <= 32'h00000005;
    sw_set(1'b1);
    chk32(cnt, 32'h00000005, "cancel start");
    chk1(ig, 1'b1, "gate open");
    i_cglc_pins_model.pulses(3, 1'b1);
    sw_set(1'b0);
    i_cglc_pins_model.pulses(2, 1'b1);
    chk32(cnt, 32'h00000008, "closed gate holds");
    sw_set(1'b1);
    chk32(cnt, 32'h00000005, "cancel restart");
    cfg.gate_stop <= 1'b1;
    i_cglc_pins_model.pulses(2, 1'b1);
    sw_set(1'b0);
    sw_set(1'b1);
    chk32(cnt, 32'h00000007, "stop continue");
    $display("test soft gate done");
  endtask : t_soft_gate
  task automatic t_hard_gate;
    cfg.gate_stop <= 1'b0;
    cfg.hardware_gate_input_en <= 1'b1;
    step(2);
    chk1(ig, 1'b0, "hw low closes");
    i_cglc_pins_model.hwg(1'b1);
    chk32(cnt, 32'h00000005, "hw rise reload");
    chk1(ig, 1'b1, "both open");
    i_cglc_pins_model.pulses(1, 1'b1);
    sw_set(1'b0);
    chk1(ig, 1'b0, "sw low closes");
    sw_set(1'b1);
    chk32(cnt, 32'h00000006, "sw rise continue");
    cfg.gate_stop <= 1'b1;
    i_cglc_pins_model.hwg(1'b0);
    i_cglc_pins_model.hwg(1'b1);
    chk32(cnt, 32'h00000006, "stop hw continue");
    $display("test hard gate done");
  endtask : t_hard_gate
  task automatic t_latch;
    cfg.hardware_gate_input_en <= 1'b0;
    i_cglc_pins_model.pulses(2, 1'b1);
    i_cglc_pins_model.latch();
    chk32(lat, 32'h00000008, "latch capture");
    i_cglc_pins_model.pulses(1, 1'b1);
    sw_set(1'b0);
    i_cglc_pins_model.latch();
    sw_set(1'b1);
    chk32(lat, 32'h00000008, "latch kept");
    $display("test latch done");
  endtask : t_latch
  task automatic t_compare;
    cfg.plain_do <= 1'b1;
    step(3);
    chk1(dout, 1'b1, "plain output");
    chk1(cst, 1'b0, "none cmp status");
    chk1(ost, 1'b0, "none out status");
    cfg.plain_do <= 1'b0;
    cfg.cmp_mode <= CGLC_CMP_GE;
    cfg.cmp_value <= 32'h0000000B;
    cfg.ctrl_do <= 1'b1;
    step(3);
    chk1(cst, 1'b0, "ge below");
    i_cglc_pins_model.pulses(2, 1'b1);
    chk1(dout, 1'b1, "ge output");
    chk1(cst, 1'b1, "ge status");
    chk1(ost, 1'b1, "ge out status");
    chk32(irq_cnt, 32'h00000001, "ge interrupt");
    i_cglc_pins_model.pulses(1, 1'b0);
    chk1(cst, 1'b0, "ge clears");
    cfg.cmp_mode <= CGLC_CMP_LE;
    step(3);
    chk1(cst, 1'b1, "le status");
    $display("test compare done");
  endtask : t_compare
  task automatic t_pulse;
    cfg.cmp_mode <= CGLC_CMP_PULSE;
    cfg.cmp_value <= 32'h0000000C;
    cfg.pulse_units <= 8'h02;
    cfg.dir_mode <= CGLC_DIR_UP;
    i_cglc_pins_model.pulses(1, 1'b1);
    n = 0;
    fork
      begin
        i_cglc_pins_model.pulses(1, 1'b1);
        cfg.pulse_units <= 8'h03;
      end
      begin
        repeat (20) if (dout !== 1'b1) @(negedge clk);
        chk1(cst, 1'b1, "pulse status");
        chk1(ost, 1'b1, "pulse out status");
        while (dout === 1'b1 && n < 40) begin
          n++;
          @(negedge clk);
        end
      end
    join
    chk32(n, 32'h00000008, "pulse length");
    chk1(cst, 1'b0, "status after pulse");
    chk32(irq_cnt, 32'h00000003, "pulse interrupt");
    step(1);
    i_cglc_pins_model.pulses(1, 1'b1);
    seen = 1'b0;
    fork
      i_cglc_pins_model.pulses(1, 1'b0);
      repeat (14) begin
        @(negedge clk);
        seen = seen | dout;
      end
    join
    chk1(seen, 1'b0, "wrong direction");
    $display("test pulse done");
  endtask : t_pulse
  task automatic t_once;
    step(1);
    cfg.count_once <= 1'b1;
    cfg.end_value <= 32'h0000000E;
    cfg.load_value <= 32'h0000000A;
    i_cglc_pins_model.pulses(2, 1'b1);
    chk32(cnt, 32'h0000000A, "once reload");
    chk1(ig, 1'b0, "once closed");
    cfg.hardware_gate_input_en <= 1'b1;
    sw_set(1'b0);
    sw_set(1'b1);
    chk1(ig, 1'b0, "once sw only");
    i_cglc_pins_model.hwg(1'b0);
    i_cglc_pins_model.hwg(1'b1);
    chk1(ig, 1'b1, "once hw reopen");
    chk32(cnt, 32'h0000000A, "once reopen load");
    $display("test count once done");
  endtask : t_once
  task automatic t_hyst;
    cfg.hysteresis <= 8'h03;
    i_cglc_pins_model.pulses(2, 1'b1);
    chk32(irq_cnt, 32'h00000004, "hyst first pulse");
    i_cglc_pins_model.pulses(1, 1'b0);
    i_cglc_pins_model.pulses(1, 1'b1);
    chk32(irq_cnt, 32'h00000004, "hyst blocks pulse");
    chk1(dout, 1'b0, "hyst output idle");
    ce <= 1'b0;
    i_cglc_pins_model.pulses(1, 1'b1);
    ce <= 1'b1;
    step(4);
    chk32(cnt, 32'h0000000C, "frozen by ce");
    $display("test hysteresis done");
  endtask : t_hyst
  // ==========================================
  // Interrupt pulse counter
  always @(posedge clk) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
  // ==========================================
  // Main sequence and watchdog
  initial begin
    step(3);
    srst <= 1'b0;
    step(1);
    chk32(cnt, CNT_RST, "reset count");
    chk32(lat, CNT_RST, "reset latch");
    t_soft_gate();
    t_hard_gate();
    t_latch();
    t_compare();
    t_pulse();
    t_once();
    t_hyst();
    end_of_test();
  end
  initial begin
    step(4000);
    bad_count++;
    end_of_test();
  end
endmodule : cglc_top_tb
